// [hdl/php_dac.sv]
// Purpose: unit element enables for three 6-bit colour fields
// Assumes: colour is stable from a flip-flop in the caller
// Notes:   one cycle of latency; the level is the count of live units
`include "php_defs.svh"
module php_dac
(
	input  wire logic aclk,
	input  wire logic aresetn,
	php_dac_if.dac    bus
);
	import php_pkg::*;

	php_dac_state_s st_ff;
	php_dac_state_s nxt_st;

	// thermometer code: unit i lives when i is below the code
	function automatic php_units_t php_therm(input logic [5:0] code);
		php_units_t u;
		u = '0;
		for (int i = 0; i < `PHP_UNITS; i++)
		begin
			u[i] = (6'(i) < code);
		end
		return u;
	endfunction

	// sum of live units, which equals the code by construction
	function automatic logic [5:0] php_count(input php_units_t u);
		logic [5:0] n;
		n = '0;
		for (int i = 0; i < `PHP_UNITS; i++)
		begin
			n = n + {5'd0, u[i]};
		end
		return n;
	endfunction

	// ****************************************************************
	// conversion per channel
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.units[2] = php_therm(bus.colour[`PHP_RED_LSB +: `PHP_FLD_W]);
		nxt_st.units[1] = php_therm(bus.colour[`PHP_GRN_LSB +: `PHP_FLD_W]);
		nxt_st.units[0] = php_therm(bus.colour[`PHP_BLU_LSB +: `PHP_FLD_W]);
		for (int c = 0; c < 3; c++)
		begin
			nxt_st.level[c] = php_count(nxt_st.units[c]);
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign bus.units = st_ff.units;
	assign bus.level = st_ff.level;
endmodule

// [hdl/php_top.sv]
// Purpose: byte-wide host port of a colour look-up table and converter
// Assumes: host strobes and data are synchronous to aclk
// Notes:   aclk is also the pixel rate; table transfers steal one pixel
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "php_defs.svh"
module php_top
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [31:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [31:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                host_rd_n,
	input  wire logic                host_wr_n,
	input  wire logic                reg_select_lo,
	input  wire logic                reg_select_hi,
	input  wire logic [7:0]          host_data_bus_i,
	output logic [7:0]               host_data_bus_o,
	output logic                     host_data_bus_oe,
	input  wire logic [7:0]          pixel_addr,
	output php_pkg::php_colour_t     pixel_colour,
	output php_pkg::php_units_t      red_units,
	output php_pkg::php_units_t      green_units,
	output php_pkg::php_units_t      blue_units,
	output logic [5:0]               red_level,
	output logic [5:0]               green_level,
	output logic [5:0]               blue_level
);
	import php_pkg::*;

	php_state_s st_ff;
	php_state_s nxt_st;
	php_dac_if  dac_bus ();

	// ****************************************************************
	// helpers
	// ****************************************************************

	// byte the host sees for a select code
	function automatic logic [7:0] php_read_val(
		input logic [1:0]  sel,
		input php_state_s  s
	);
		logic [7:0] v;
		v = s.addr;
		if (sel == `PHP_SEL_COLOUR)
		begin
			// top two bits read as zero
			case (s.phase)
				`PHP_PH_RED: v = {2'b00, s.cbuf[`PHP_RED_LSB +: `PHP_FLD_W]};
				`PHP_PH_GRN: v = {2'b00, s.cbuf[`PHP_GRN_LSB +: `PHP_FLD_W]};
				default:     v = {2'b00, s.cbuf[`PHP_BLU_LSB +: `PHP_FLD_W]};
			endcase
		end
		else if (sel == `PHP_SEL_MASK)
			v = s.mask;
		return v;
	endfunction

	// next byte position in the red, green, blue walk
	function automatic logic [1:0] php_next_phase(input logic [1:0] ph);
		logic [1:0] n;
		n = ph + 2'd1;
		if (ph == `PHP_PH_BLU)
			n = `PHP_PH_RED;
		return n;
	endfunction

	// ****************************************************************
	// strobe edges
	// ****************************************************************
	logic       rd_fall;
	logic       rd_rise;
	logic       wr_fall;
	logic       wr_rise;
	logic [1:0] pin_sel;
	logic       aw_hs;
	logic       w_hs;
	logic       ar_hs;
	logic       do_write;
	logic [31:0] status_word;

	// inputs are synchronous, so one stored copy is enough for edges
	always_comb
	begin
		pin_sel = {reg_select_hi, reg_select_lo};
		rd_fall = st_ff.rd_n_q & ~host_rd_n & host_wr_n;
		rd_rise = ~st_ff.rd_n_q & host_rd_n;
		// a write strobe while a read is open is ignored
		wr_fall = st_ff.wr_n_q & ~host_wr_n & host_rd_n;
		wr_rise = ~st_ff.wr_n_q & host_wr_n & st_ff.rd_n_q;
	end

	// bus handshakes
	assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
	assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
	assign s_axi_arready = ~st_ff.rvalid;
	assign aw_hs         = s_axi_awvalid & s_axi_awready;
	assign w_hs          = s_axi_wvalid & s_axi_wready;
	assign ar_hs         = s_axi_arvalid & s_axi_arready;
	assign do_write      = st_ff.aw_got & st_ff.w_got;

	// status word shows the host port's own state
	always_comb
	begin
		status_word = '0;
		status_word[`PHP_ST_ADDR_LSB +: 8] = st_ff.addr;
		status_word[`PHP_ST_PH_LSB +: 2]   = st_ff.phase;
		status_word[`PHP_ST_MASK_LSB +: 8] = st_ff.mask;
		status_word[`PHP_ST_BUSY]          = (st_ff.op != PHP_OP_NONE);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rd_n_q = host_rd_n;
		nxt_st.wr_n_q = host_wr_n;
		nxt_st.op     = PHP_OP_NONE;

		// lookup slot: a pending transfer takes this pixel's place
		case (st_ff.op)
			PHP_OP_STORE:
			begin
				nxt_st.lut[st_ff.addr] = st_ff.cbuf;
				nxt_st.colour = st_ff.cbuf;
				nxt_st.addr = st_ff.addr + `PHP_ADDR_STEP;
			end
			PHP_OP_FETCH:
			begin
				nxt_st.cbuf = st_ff.lut[st_ff.addr];
				nxt_st.colour = st_ff.lut[st_ff.addr];
				nxt_st.addr = st_ff.addr + `PHP_ADDR_STEP;
			end
			default:
			begin
				// normal pixel lookup through the mask
				nxt_st.colour = st_ff.lut[pixel_addr & st_ff.mask];
			end
		endcase

		// select is caught as a strobe opens the cycle
		if (rd_fall | wr_fall)
			nxt_st.sel = pin_sel;

		// read drive: opens on the fall, ends on the rise
		if (rd_fall)
		begin
			nxt_st.doe  = 1'b1;
			nxt_st.dout = php_read_val(pin_sel, st_ff);
		end
		else if (rd_rise)
		begin
			nxt_st.doe = 1'b0;
		end
		else if (st_ff.doe)
		begin
			nxt_st.dout = php_read_val(st_ff.sel, st_ff);
		end

		// end of read: colour walk advances, refetch after blue
		if (rd_rise && st_ff.sel == `PHP_SEL_COLOUR)
		begin
			nxt_st.phase = php_next_phase(st_ff.phase);
			if (st_ff.phase == `PHP_PH_BLU)
				nxt_st.op = PHP_OP_FETCH;
		end

		// end of write: data taken on the rising write strobe
		if (wr_rise)
		begin
			case (st_ff.sel)
				`PHP_SEL_ADDR_WR:
				begin
					nxt_st.addr  = host_data_bus_i;
					nxt_st.phase = `PHP_PH_RED;
				end
				`PHP_SEL_ADDR_RD:
				begin
					nxt_st.addr  = host_data_bus_i;
					nxt_st.phase = `PHP_PH_RED;
					nxt_st.op    = PHP_OP_FETCH;
				end
				`PHP_SEL_COLOUR:
				begin
					case (st_ff.phase)
						`PHP_PH_RED: nxt_st.cbuf[`PHP_RED_LSB +: `PHP_FLD_W] =
							host_data_bus_i[`PHP_FLD_W-1:0];
						`PHP_PH_GRN: nxt_st.cbuf[`PHP_GRN_LSB +: `PHP_FLD_W] =
							host_data_bus_i[`PHP_FLD_W-1:0];
						default: nxt_st.cbuf[`PHP_BLU_LSB +: `PHP_FLD_W] =
							host_data_bus_i[`PHP_FLD_W-1:0];
					endcase
					nxt_st.phase = php_next_phase(st_ff.phase);
					if (st_ff.phase == `PHP_PH_BLU)
						nxt_st.op = PHP_OP_STORE;
				end
				default:
				begin
					nxt_st.mask = host_data_bus_i;
				end
			endcase
		end

		// register bus: write address and data in either order
		if (aw_hs)
		begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			nxt_st.w_got  = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = `PHP_RESP_SLVERR;
			if (st_ff.aw_addr == `PHP_OFS_CTRL)
			begin
				nxt_st.bresp = `PHP_RESP_OKAY;
				if (st_ff.w_strb[0])
					nxt_st.blank = st_ff.w_data[`PHP_CTRL_BLANK];
			end
			else if (st_ff.aw_addr == `PHP_OFS_STATUS ||
				st_ff.aw_addr == `PHP_OFS_COLOUR)
				nxt_st.bresp = `PHP_RESP_OKAY; // read-only, write dropped
		end
		else if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
		end

		// register bus: reads answer one cycle after the address
		if (ar_hs)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = `PHP_RESP_OKAY;
			nxt_st.rdata  = '0;
			if (s_axi_araddr == `PHP_OFS_CTRL)
				nxt_st.rdata[`PHP_CTRL_BLANK] = st_ff.blank;
			else if (s_axi_araddr == `PHP_OFS_STATUS)
				nxt_st.rdata = status_word;
			else if (s_axi_araddr == `PHP_OFS_COLOUR)
				nxt_st.rdata = {14'd0, st_ff.colour};
			else
				nxt_st.rresp = `PHP_RESP_SLVERR;
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************

	// table clears at reset too; costly in area but keeps sims clean
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff        <= '0;
			st_ff.mask   <= `PHP_RST_MASK;
			st_ff.rd_n_q <= `PHP_RST_STROBE;
			st_ff.wr_n_q <= `PHP_RST_STROBE;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// converter and outputs
	// ****************************************************************
	assign dac_bus.colour = st_ff.blank ? '0 : st_ff.colour;

	php_dac u_dac
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.bus     (dac_bus.dac)
	);

	assign s_axi_bvalid     = st_ff.bvalid;
	assign s_axi_bresp      = st_ff.bresp;
	assign s_axi_rvalid     = st_ff.rvalid;
	assign s_axi_rdata      = st_ff.rdata;
	assign s_axi_rresp      = st_ff.rresp;
	assign host_data_bus_o  = st_ff.dout;
	assign host_data_bus_oe = st_ff.doe;
	assign pixel_colour     = st_ff.colour;
	assign red_units        = dac_bus.units[2];
	assign green_units      = dac_bus.units[1];
	assign blue_units       = dac_bus.units[0];
	assign red_level        = dac_bus.level[2];
	assign green_level      = dac_bus.level[1];
	assign blue_level       = dac_bus.level[0];
endmodule

// [pkg/php_dac_if.sv]
// Purpose: carries colour word to the converter and its results back
// Assumes: both ends share aclk
// Notes:   index 2 red, 1 green, 0 blue
interface php_dac_if;
	logic [17:0]      colour;
	logic [2:0][62:0] units;
	logic [2:0][5:0]  level;

	modport drv (output colour, input units, input level);
	modport dac (input colour, output units, output level);
endinterface

// [pkg/php_defs.svh]
// Purpose: constants of the palette host port
// Assumes: one clock, aclk, which also paces the pixel stream
// Notes:   the constants are named here; field widths and zero padding in the logic stay bare
// Function
// - register select is latched when the strobe that opens a cycle falls.
// - a write takes the data byte when the write strobe rises.
// - a read drives the chosen register until the read strobe rises.
// - each 6-bit colour field turns on that many of 63 unit elements.
// - select 00 loads the address; select 11 loads and prefetches.
// - select 01 moves the colour buffer as red, green, blue bytes.
// - select 10 is the pixel mask, which the host path ignores.
`ifndef PHP_DEFS_SVH
`define PHP_DEFS_SVH

// ****************************************************************
// host port select codes
// ****************************************************************
`define PHP_SEL_ADDR_WR  2'b00
`define PHP_SEL_COLOUR   2'b01
`define PHP_SEL_MASK     2'b10
`define PHP_SEL_ADDR_RD  2'b11

// ****************************************************************
// colour buffer layout and byte sequence
// ****************************************************************
`define PHP_FLD_W        6
`define PHP_RED_LSB      12
`define PHP_GRN_LSB      6
`define PHP_BLU_LSB      0
`define PHP_PH_RED       2'd0
`define PHP_PH_GRN       2'd1
`define PHP_PH_BLU       2'd2
`define PHP_UNITS        63

// ****************************************************************
// reset values and address step
// ****************************************************************
`define PHP_RST_MASK     8'hff
`define PHP_RST_STROBE   1'b1
`define PHP_ADDR_STEP    8'h01

// ****************************************************************
// register bus map and answers
// ****************************************************************
`define PHP_OFS_CTRL     32'h0000_0000
`define PHP_OFS_STATUS   32'h0000_0004
`define PHP_OFS_COLOUR   32'h0000_0008
`define PHP_CTRL_BLANK   0
`define PHP_ST_ADDR_LSB  0
`define PHP_ST_PH_LSB    8
`define PHP_ST_MASK_LSB  16
`define PHP_ST_BUSY      24
`define PHP_RESP_OKAY    2'b00
`define PHP_RESP_SLVERR  2'b10

`endif

// [pkg/php_pkg.sv]
// Purpose: types shared by the palette host port modules
// Assumes: constants come from php_defs.svh
// Notes:   state of each module is one packed struct
package php_pkg;

	// ****************************************************************
	// table transfer pending in the lookup slot
	// ****************************************************************
	typedef enum logic [1:0]
	{
		PHP_OP_NONE,
		PHP_OP_STORE,
		PHP_OP_FETCH
	} php_op_e;

	typedef logic [17:0] php_colour_t;
	typedef logic [62:0] php_units_t;

	// ****************************************************************
	// state of the top module
	// ****************************************************************
	typedef struct packed {
		logic [255:0][17:0] lut;
		logic [7:0]         addr;
		logic [1:0]         phase;
		php_colour_t        cbuf;
		logic [7:0]         mask;
		logic [1:0]         sel;
		php_op_e            op;
		logic               rd_n_q;
		logic               wr_n_q;
		logic [7:0]         dout;
		logic               doe;
		php_colour_t        colour;
		logic               blank;
		logic               aw_got;
		logic [31:0]        aw_addr;
		logic               w_got;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} php_state_s;

	// ****************************************************************
	// state of the converter module
	// ****************************************************************
	typedef struct packed {
		logic [2:0][62:0] units;
		logic [2:0][5:0]  level;
	} php_dac_state_s;

endpackage

// [tb/php_host_bfm.sv]
// Purpose: host processor model on the byte-wide strobe port
// Assumes: strobes move just after rising edges of aclk
// Notes:   a released bus shows a moving pattern, never a held value
module php_host_bfm
(
	input  wire logic       aclk,
	output logic            rd_n,
	output logic            wr_n,
	output logic            sel_lo,
	output logic            sel_hi,
	output logic [7:0]      bus,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] drv;
	logic [7:0] last;
	logic       drv_en;

	// resolved data line, inverse of last level when nobody drives
	assign bus = dev_oe ? dev_data : (drv_en ? drv : ~last);
	always @(posedge aclk)
		last <= bus;
	initial
	begin
		{rd_n, wr_n, sel_hi, sel_lo, drv_en} = 5'b11000;
		drv = 8'h00;
		last = 8'h00;
	end
	// one strobe at a time, four idle clocks after each; s2 moves the
	// select pins mid-cycle to prove the latched value is used
	task automatic wr(input logic [1:0] s, s2, input logic [7:0] d);
		{sel_hi, sel_lo} <= s;
		drv <= d;
		drv_en <= 1'b1;
		wr_n <= 1'b0;
		@(posedge aclk);
		{sel_hi, sel_lo} <= s2;
		repeat (2) @(posedge aclk);
		wr_n <= 1'b1;
		@(posedge aclk);
		drv_en <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		{sel_hi, sel_lo} <= s;
		rd_n <= 1'b0;
		repeat (3) @(posedge aclk);
		d = bus;
		rd_n <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask
endmodule

// [tb/php_top_sva.sv]
// Purpose: port-level checks of the palette host port
// Assumes: one clock, aclk, with synchronous active-low reset
// Notes:   sees only the top ports; attached by the bind at the foot
module php_top_sva
(
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic                host_rd_n,
	input wire logic                host_wr_n,
	input wire logic                host_data_bus_oe,
	input wire php_pkg::php_units_t red_units,
	input wire logic [5:0]          red_level,
	input wire php_pkg::php_units_t blue_units,
	input wire logic [5:0]          blue_level
);
	timeunit 1ns;
	timeprecision 1ns;
	import php_pkg::*;
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// a read fall seen with write idle drives the bus next cycle
	property p_oe_on;
		host_wr_n && !host_rd_n && $past(host_rd_n) |=> host_data_bus_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("read strobe did not drive the bus");
	// bus released the cycle after the read strobe rises
	property p_oe_off;
		host_rd_n && !$past(host_rd_n) |=> !host_data_bus_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("bus still driven after read ended");
	// never drive unless a read was open one edge earlier
	property p_oe_cause;
		host_data_bus_oe |-> !$past(host_rd_n);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("bus driven without a read");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	// a pending response blocks both write channels
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block)
		else $error("write accepted while response pending");
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans)
		else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data moved before taken");
	// thermometer code: exactly level units live
	property p_red_units;
		red_units == (63'h1 << red_level) - 63'h1;
	endproperty
	a_red_units: assert property (p_red_units)
		else $error("red units do not match level");
	property p_blu_units;
		blue_units == (63'h1 << blue_level) - 63'h1;
	endproperty
	a_blu_units: assert property (p_blu_units)
		else $error("blue units do not match level");
endmodule

bind php_top php_top_sva u_sva
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .host_data_bus_oe(host_data_bus_oe),
	.red_units(red_units), .red_level(red_level),
	.blue_units(blue_units), .blue_level(blue_level)
);

// [tb/tb_palette_host_port.sv]
// Purpose: self-checking bench of the palette host port
// Assumes: host strobes come from the partner model on aclk
// Notes:   AXI waits carry no cycle count; the watchdog ends hangs
`include "php_defs.svh"
`define CHK(a, e) \
	begin \
		n_compared++; \
		if ((a) !== (e)) \
		begin \
			n_fail++; \
			$display("BAD %0t: got %h exp %h", $time, (a), (e)); \
		end \
	end
module tb_palette_host_port;
	timeunit 1ns;
	timeprecision 1ns;
	import php_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        rd_n, wr_n, sel_lo, sel_hi, oe;
	logic [7:0]  bus_i, bus_o, pix;
	php_colour_t pcol;
	php_units_t  ru, gu, bu;
	logic [5:0]  rl, gl, bl;
	int          n_fail, n_compared;

	php_top uut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .host_rd_n(rd_n), .host_wr_n(wr_n),
		.reg_select_lo(sel_lo), .reg_select_hi(sel_hi),
		.host_data_bus_i(bus_i), .host_data_bus_o(bus_o),
		.host_data_bus_oe(oe), .pixel_addr(pix), .pixel_colour(pcol),
		.red_units(ru), .green_units(gu), .blue_units(bu),
		.red_level(rl), .green_level(gl), .blue_level(bl)
	);
	php_host_bfm host
	(
		.aclk(aclk), .rd_n(rd_n), .wr_n(wr_n), .sel_lo(sel_lo),
		.sel_hi(sel_hi), .bus(bus_i), .dev_data(bus_o), .dev_oe(oe)
	);

	// ****************************************************************
	// clock, watchdog and verdict
	// ****************************************************************
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// whole run is well under a thousand clocks
	initial
	begin
		repeat (5000) @(posedge aclk);
		n_fail++;
		summarize();
	end
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************************************
	// register bus and check tasks
	// ****************************************************************
	task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
		logic ga;
		logic gw;
		{ga, gw} = 2'b00;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid} <= 2'b11;
		do
		begin
			@(posedge aclk);
			ga = ga || awready;
			gw = gw || wready;
			awvalid <= !ga;
			wvalid <= !gw;
		end while (!(ga && gw));
		// ready raised late so an unanswered response must hold
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		// ready raised late so read data must hold while unanswered
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	task automatic chk_st(input logic [7:0] a, input logic [1:0] ph,
		input logic [7:0] m);
		logic [31:0] d;
		logic [1:0]  r;
		axr(`PHP_OFS_STATUS, d, r);
		`CHK(d, {8'h00, m, 6'h00, ph, a})
	endtask
	// converter sees zero while blanked, lookup output does not
	task automatic chk_pix(input logic [7:0] p, input php_colour_t c,
		input logic blank);
		php_colour_t z;
		z = blank ? 18'h00000 : c;
		pix <= p;
		repeat (4) @(posedge aclk);
		`CHK(pcol, c)
		`CHK({rl, gl, bl}, z)
		`CHK(ru, (63'h1 << z[17:12]) - 63'h1)
		`CHK(gu, (63'h1 << z[11:6]) - 63'h1)
		`CHK(bu, (63'h1 << z[5:0]) - 63'h1)
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  b;
		php_colour_t c5;
		c5 = {6'h01, 6'h2a, 6'h3f};
		{n_fail, n_compared} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr, pix} = '0;
		wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk_st(8'h00, 2'd0, `PHP_RST_MASK);
		axr(32'h0000_0010, d, r);
		`CHK({r, d}, {`PHP_RESP_SLVERR, 32'h0})
		axw(32'h0000_0010, 32'h1, r);
		`CHK(r, `PHP_RESP_SLVERR)
		// colour bytes with top bits set; only the low six count
		host.wr(`PHP_SEL_ADDR_WR, `PHP_SEL_ADDR_WR, 8'h05);
		host.wr(`PHP_SEL_COLOUR, `PHP_SEL_MASK, 8'hc1);
		chk_st(8'h05, 2'd1, 8'hff);
		host.wr(`PHP_SEL_COLOUR, `PHP_SEL_COLOUR, 8'h6a);
		host.wr(`PHP_SEL_COLOUR, `PHP_SEL_COLOUR, 8'h7f);
		chk_st(8'h06, 2'd0, 8'hff);
		chk_pix(8'h05, c5, 1'b0);
		axw(`PHP_OFS_CTRL, 32'h1, r);
		chk_pix(8'h05, c5, 1'b1);
		axw(`PHP_OFS_CTRL, 32'h0, r);
		axw(`PHP_OFS_STATUS, 32'hffff_ffff, r);
		`CHK(r, `PHP_RESP_OKAY)
		// mask latched though the select pins move before the rise
		host.wr(`PHP_SEL_MASK, `PHP_SEL_COLOUR, 8'h00);
		chk_st(8'h06, 2'd0, 8'h00);
		chk_pix(8'h05, 18'h00000, 1'b0);
		// host reads ignore the mask
		host.wr(`PHP_SEL_ADDR_RD, `PHP_SEL_ADDR_RD, 8'h05);
		chk_st(8'h06, 2'd0, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			host.rd(`PHP_SEL_COLOUR, b);
			`CHK(b, {2'b00, c5[17 - 6 * i -: 6]})
		end
		chk_st(8'h07, 2'd0, 8'h00);
		host.rd(`PHP_SEL_ADDR_WR, b);
		`CHK(b, 8'h07)
		host.rd(`PHP_SEL_ADDR_RD, b);
		`CHK(b, 8'h07)
		host.rd(`PHP_SEL_MASK, b);
		`CHK(b, 8'h00)
		host.wr(`PHP_SEL_MASK, `PHP_SEL_MASK, 8'hff);
		chk_pix(8'h05, c5, 1'b0);
		summarize();
	end
endmodule
